// ===== fpc_pkg.sv
package fpc_pkg;
    localparam logic [11:0] FPC_ADDR_CMD_STATE = 12'hFF8;
    localparam logic [11:0] FPC_ADDR_PROT_PAGE = 12'hFF9;
    localparam logic [7:0] FPC_CMD_RESET = 8'h00;
    localparam logic [7:0] FPC_CMD_UNLOCK1 = 8'h73;
    localparam logic [7:0] FPC_CMD_UNLOCK2 = 8'h8C;
    localparam logic [7:0] FPC_CMD_PROT_SEL = 8'h5E;
    localparam logic [7:0] FPC_CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] FPC_CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] FPC_PROT_RESET = 8'h00;
    localparam logic [7:0] FPC_PAGE_RESET = 8'h00;
    localparam logic [7:0] FPC_ERASED_BYTE = 8'hFF;
    localparam logic [5:0] FPC_ST_LOCKED = 6'h00;
    localparam logic [5:0] FPC_ST_UNLOCK1 = 6'h01;
    localparam logic [5:0] FPC_ST_UNLOCK2 = 6'h02;
    localparam logic [5:0] FPC_ST_UNLOCKED = 6'h03;
    localparam logic [5:0] FPC_ST_PROT_SEL = 6'h04;
    localparam logic [5:0] FPC_ST_PROGRAM = 6'h08;
    localparam logic [5:0] FPC_ST_PAGE_ERASE = 6'h10;
    localparam logic [5:0] FPC_ST_MASS_ERASE = 6'h20;
    localparam int FPC_ADDR_W = 13;
    localparam int FPC_PAGE_POS = 9;
    localparam int FPC_SECTOR_POS = 10;
    localparam logic [15:0] FPC_PROG_CYCLES = 16'h0004;
    localparam logic [15:0] FPC_ERASE_CYCLES = 16'h0010;
    typedef enum logic [8:0] {
        FPC_LOCKED = 9'h001,
        FPC_UNL1 = 9'h002,
        FPC_UNL2 = 9'h004,
        FPC_UNLOCKED = 9'h008,
        FPC_PROTSEL = 9'h010,
        FPC_PAGE_EN = 9'h020,
        FPC_MASS_EN = 9'h040,
        FPC_BUSY_PROG = 9'h080,
        FPC_BUSY_ERASE = 9'h100
    } fpc_state_t;
endpackage

// ===== fpc_ctrl.sv
// Operation
// - Protection register writes only set bits
// - Non-5EH command deselects protection register
// - Protection register clears on reset
// - Protected sectors refuse program and erase
// - Program only after unlock and erase enable
// - Mass enables all; page enables one page
// - Erased reads FFH; program clears bits only
// - Accept debugger and processor program requests
// - Processor stalled while byte programs
// - Other command ends programming, relocks; 5EH selects protection register
// - State reads at FF8H, commands write there
// - Codes 00,01,02,03 for unlock sequence
// - Codes 04, 001xxx, 010xxx, 100xxx
// - State bits 7:6 read zero
module fpc_ctrl
    import fpc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic cpu_prog_i,
    input wire logic dbg_prog_i,
    input wire logic [FPC_ADDR_W-1:0] prog_addr_i,
    input wire logic [7:0] prog_data_i,
    input wire logic [FPC_ADDR_W-1:0] mem_addr_i,
    output logic [7:0] mem_rdata_o,
    output logic cpu_stall_o,
    output logic prog_refused_o
);
    localparam int DEPTH = 1 << FPC_ADDR_W;
    logic [7:0] mem [DEPTH];
    fpc_state_t state;
    fpc_state_t next_state;
    logic [7:0] prot;
    logic [7:0] page;
    logic [15:0] cnt;
    logic erase_mass;
    logic [7:0] erase_page;
    logic [FPC_ADDR_W-1:0] pa;
    logic [7:0] pd;
    logic [5:0] code;

    wire cmd_wr = reg_wr_i && reg_addr_i == FPC_ADDR_CMD_STATE;
    wire pp_wr = reg_wr_i && reg_addr_i == FPC_ADDR_PROT_PAGE;
    wire prog_req = cpu_prog_i || dbg_prog_i;
    wire [7:0] req_sector = 8'(prog_addr_i >> FPC_SECTOR_POS);
    wire [7:0] req_page = 8'(prog_addr_i >> FPC_PAGE_POS);
    wire [7:0] page_sector = 8'(page >> (FPC_SECTOR_POS - FPC_PAGE_POS));
    wire req_protected = prot[req_sector[2:0]];
    wire page_protected = prot[page_sector[2:0]];
    wire window_ok = state == FPC_MASS_EN || (state == FPC_PAGE_EN && req_page == page);
    wire prog_ok = prog_req && window_ok && !req_protected;
    wire erase_page_ok = cmd_wr && reg_wdata_i == FPC_CMD_PAGE_ERASE
        && state == FPC_UNLOCKED && !page_protected;
    wire erase_mass_ok = cmd_wr && reg_wdata_i == FPC_CMD_MASS_ERASE
        && state == FPC_UNLOCKED && prot == FPC_PROT_RESET;
    wire busy_done = cnt == 16'h0001;

    always_comb begin
        next_state = state;
        case (state)
            FPC_BUSY_PROG: if (busy_done) next_state = erase_mass ? FPC_MASS_EN : FPC_PAGE_EN;
            FPC_BUSY_ERASE: if (busy_done) next_state = erase_mass ? FPC_MASS_EN : FPC_PAGE_EN;
            default: begin
                if (cmd_wr) begin
                    next_state = FPC_LOCKED;
                    if (reg_wdata_i == FPC_CMD_UNLOCK1 && state == FPC_LOCKED) begin
                        next_state = FPC_UNL1;
                    end
                    if (reg_wdata_i == FPC_CMD_UNLOCK2 && state == FPC_UNL1) begin
                        next_state = FPC_UNL2;
                    end
                    if (state == FPC_UNL2 && reg_wdata_i == page) begin
                        next_state = FPC_UNLOCKED;
                    end
                    if (reg_wdata_i == FPC_CMD_PROT_SEL) next_state = FPC_PROTSEL;
                    if (erase_page_ok || erase_mass_ok) next_state = FPC_BUSY_ERASE;
                end else if (prog_ok) begin
                    next_state = FPC_BUSY_PROG;
                end
            end
        endcase
    end

    always_comb begin
        case (state)
            FPC_LOCKED: code = FPC_ST_LOCKED;
            FPC_UNL1: code = FPC_ST_UNLOCK1;
            FPC_UNL2: code = FPC_ST_UNLOCK2;
            FPC_UNLOCKED: code = FPC_ST_UNLOCKED;
            FPC_PAGE_EN: code = FPC_ST_UNLOCKED;
            FPC_MASS_EN: code = FPC_ST_UNLOCKED;
            FPC_PROTSEL: code = FPC_ST_PROT_SEL;
            FPC_BUSY_PROG: code = FPC_ST_PROGRAM;
            FPC_BUSY_ERASE: code = erase_mass ? FPC_ST_MASS_ERASE : FPC_ST_PAGE_ERASE;
            default: code = FPC_ST_LOCKED;
        endcase
    end

    wire [7:0] rd_mux = reg_addr_i == FPC_ADDR_CMD_STATE ? {2'b00, code}
        : reg_addr_i == FPC_ADDR_PROT_PAGE ? (state == FPC_PROTSEL ? prot : page)
        : 8'h00;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state <= FPC_LOCKED;
            prot <= FPC_PROT_RESET;
            page <= FPC_PAGE_RESET;
            cnt <= 16'h0000;
            erase_mass <= 1'b0;
            erase_page <= 8'h00;
            pa <= '0;
            pd <= 8'h00;
            reg_rdata_o <= 8'h00;
            mem_rdata_o <= 8'h00;
        end else begin
            state <= next_state;
            if (reg_rd_i) reg_rdata_o <= rd_mux;
            mem_rdata_o <= mem[mem_addr_i];
            if (pp_wr && state == FPC_PROTSEL) prot <= prot | reg_wdata_i;
            if (pp_wr && state != FPC_PROTSEL) page <= reg_wdata_i;
            if (erase_page_ok || erase_mass_ok) begin
                erase_mass <= erase_mass_ok;
                erase_page <= page;
                cnt <= FPC_ERASE_CYCLES;
            end else if (state == FPC_MASS_EN || state == FPC_PAGE_EN) begin
                if (!cmd_wr && prog_ok) begin
                    pa <= prog_addr_i;
                    pd <= prog_data_i;
                    cnt <= FPC_PROG_CYCLES;
                end
            end else if (cnt != 16'h0000) begin
                cnt <= cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (state == FPC_BUSY_PROG && busy_done) mem[pa] <= mem[pa] & pd;
        if (state == FPC_BUSY_ERASE && busy_done) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (erase_mass || 8'(i >> FPC_PAGE_POS) == erase_page) begin
                    mem[i] <= FPC_ERASED_BYTE;
                end
            end
        end
    end

    assign cpu_stall_o = state == FPC_BUSY_PROG || state == FPC_BUSY_ERASE;
    assign prog_refused_o = prog_req && !cmd_wr && !prog_ok && !cpu_stall_o;

    a_prot_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pp_wr && state == FPC_PROTSEL)
        |=> (prot & $past(reg_wdata_i)) == $past(reg_wdata_i))
        else $error("protection bit not set");
    a_prot_never_clr: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ($past(prot) & ~prot) == 8'h00) else $error("protection lost");
    a_stall_prog: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (prog_ok && !cmd_wr) |=> cpu_stall_o [*4]) else $error("stall too short");
    a_unlock_seq: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_LOCKED && cmd_wr && reg_wdata_i == FPC_CMD_UNLOCK1)
        |=> code == FPC_ST_UNLOCK1) else $error("unlock code wrong");
    a_relock_cmd: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ((state == FPC_PAGE_EN || state == FPC_MASS_EN) && cmd_wr
        && reg_wdata_i != FPC_CMD_PAGE_ERASE && reg_wdata_i != FPC_CMD_MASS_ERASE
        && reg_wdata_i != FPC_CMD_PROT_SEL)
        |=> state == FPC_LOCKED) else $error("no relock");
    a_no_prog_lock: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_LOCKED) |=> state != FPC_BUSY_PROG) else $error("prog while locked");
    a_prog_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state == FPC_BUSY_PROG |-> code[5:3] == 3'b001) else $error("bad prog code");
    a_busy_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_BUSY_PROG && busy_done) |=> state != FPC_BUSY_PROG)
        else $error("busy never ends");
    // Sequencing, refusal and timing checks
    a_stall_prog_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ($rose(cpu_stall_o) && state == FPC_BUSY_PROG) |-> ##4 !cpu_stall_o)
        else $error("program stall wrong length");
    a_erase_len: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ($rose(cpu_stall_o) && state == FPC_BUSY_ERASE)
        |-> ##15 cpu_stall_o ##1 !cpu_stall_o) else $error("erase busy wrong length");
    a_state_readback: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (reg_rd_i && reg_addr_i == FPC_ADDR_CMD_STATE)
        |=> reg_rdata_o == {2'b00, $past(code)}) else $error("state read wrong");
    a_prot_desel: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cmd_wr && reg_wdata_i != FPC_CMD_PROT_SEL && !cpu_stall_o)
        |=> state != FPC_PROTSEL) else $error("protection still selected");
    a_refuse_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (prog_req && !cmd_wr && (state == FPC_LOCKED || state == FPC_UNLOCKED))
        |-> prog_refused_o) else $error("locked program not refused");
    a_page_window: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_PAGE_EN && prog_req && req_page != page)
        |=> !cpu_stall_o) else $error("program outside page");
    a_mass_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cmd_wr && reg_wdata_i == FPC_CMD_MASS_ERASE && prot != FPC_PROT_RESET
        && !cpu_stall_o)
        |=> !cpu_stall_o) else $error("mass erase of protected array");
    a_page_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (cmd_wr && reg_wdata_i == FPC_CMD_PAGE_ERASE && page_protected && !cpu_stall_o)
        |=> !cpu_stall_o) else $error("erase of protected page");
    a_unlock_two: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_UNL1 && cmd_wr && reg_wdata_i == FPC_CMD_UNLOCK2)
        |=> code == FPC_ST_UNLOCK2) else $error("second unlock code wrong");
    a_seq_break: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_UNL1 && cmd_wr && reg_wdata_i != FPC_CMD_UNLOCK2
        && reg_wdata_i != FPC_CMD_PROT_SEL)
        |=> state == FPC_LOCKED) else $error("broken unlock not relocked");
    a_erase_code: assert property (@(posedge clk_i) disable iff (!resetn_i)
        state == FPC_BUSY_ERASE |-> code[5:3] == (erase_mass ? 3'b100 : 3'b010))
        else $error("bad erase code");
    a_dbg_accept: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == FPC_MASS_EN && dbg_prog_i && !cmd_wr)
        |=> state == FPC_BUSY_PROG) else $error("debugger program not taken");
endmodule

// ===== fpc_host_model.sv
module fpc_host_model (
    input wire logic clk_i,
    input wire logic stall_i,
    input wire logic refused_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o = 1'b0,
    output logic rd_o = 1'b0,
    output logic [11:0] addr_o = 12'h000,
    output logic [7:0] wdata_o = 8'h00,
    output logic cpu_o = 1'b0,
    output logic dbg_o = 1'b0,
    output logic [12:0] paddr_o = 13'h0000,
    output logic [7:0] pdata_o = 8'h00
);
    timeunit 1ns;
    timeprecision 100ps;
    // Commands go out whole and one at a time
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i) #1;
        {wr_o, addr_o, wdata_o} = {1'b1, a, d};
        @(posedge clk_i) #1;
        wr_o = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_i) #1;
        {rd_o, addr_o} = {1'b1, a};
        @(posedge clk_i) #1;
        rd_o = 1'b0;
        d = rdata_i;
    endtask
    // Returns refused before the edge, stall after it
    task automatic prog(input logic dbg, input logic [12:0] a, input logic [7:0] d,
                        output logic [1:0] res);
        @(posedge clk_i) #1;
        {cpu_o, dbg_o, paddr_o, pdata_o} = {!dbg, dbg, a, d};
        #1 res[1] = refused_i;
        @(posedge clk_i) #1;
        res[0] = stall_i;
        dbg_o = 1'b0;
        for (int i = 0; i < 8 && stall_i; i++) @(posedge clk_i) #1;
        cpu_o = 1'b0;
    endtask
endmodule

// ===== flash_program_controller_test.sv
module flash_program_controller_test import fpc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CS = FPC_ADDR_CMD_STATE;
    localparam logic [11:0] PP = FPC_ADDR_PROT_PAGE;
    logic clk, resetn, wr, rd, cpu, dbg, stall, refused;
    logic [11:0] addr;
    logic [7:0] wdata, rdata, pdata, mdata, v;
    logic [12:0] paddr, maddr;
    logic [1:0] res;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [15:0] rows [8] = '{16'h7301, 16'h8C02, 16'h0003, 16'h1100,
        16'h7301, 16'h7300, 16'h5E04, 16'h0000};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    fpc_ctrl u_dut (.clk_i(clk), .resetn_i(resetn), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .cpu_prog_i(cpu),
        .dbg_prog_i(dbg), .prog_addr_i(paddr), .prog_data_i(pdata), .mem_addr_i(maddr),
        .mem_rdata_o(mdata), .cpu_stall_o(stall), .prog_refused_o(refused));
    fpc_host_model u_host (.clk_i(clk), .stall_i(stall), .refused_i(refused),
        .rdata_i(rdata), .wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata),
        .cpu_o(cpu), .dbg_o(dbg), .paddr_o(paddr), .pdata_o(pdata));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic st(input logic [7:0] mask, input logic [7:0] exp);
        u_host.rd(CS, v);
        check(v & mask, exp);
    endtask
    task automatic mem(input logic [12:0] a, input logic [7:0] exp);
        @(posedge clk) #1 maddr = a;
        @(posedge clk) #1 check(mdata, exp);
    endtask
    task automatic unl(input logic [7:0] page);
        u_host.wr(CS, FPC_CMD_UNLOCK1);
        u_host.wr(CS, FPC_CMD_UNLOCK2);
        u_host.wr(CS, page);
    endtask
    task automatic erase(input logic [7:0] cmd, input logic [7:0] code);
        u_host.wr(CS, cmd);
        check({7'h00, stall}, 8'h01);
        st(8'hF8, code);
        for (int i = 0; i < 40 && stall; i++) @(posedge clk) #1;
        st(8'hFF, 8'h03);
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial begin
        {resetn, maddr} = {1'b0, 13'h0000};
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
        st(8'hFF, 8'h00);
        foreach (rows[i]) begin
            u_host.wr(CS, rows[i][15:8]);
            st(8'hFF, rows[i][7:0]);
        end
        $display("command table done");
        u_host.wr(CS, FPC_CMD_PROT_SEL);
        u_host.wr(PP, 8'h01);
        u_host.wr(PP, 8'h00);
        u_host.rd(PP, v);
        check(v, 8'h01);
        u_host.wr(CS, FPC_CMD_RESET);
        u_host.wr(PP, 8'h02);
        u_host.rd(PP, v);
        check(v, 8'h02);
        unl(8'h02);
        u_host.wr(CS, FPC_CMD_MASS_ERASE);
        st(8'hFF, 8'h00);
        unl(8'h02);
        erase(FPC_CMD_PAGE_ERASE, 8'h10);
        mem(13'h0400, 8'hFF);
        u_host.prog(1'b0, 13'h0400, 8'hA5, res);
        check({6'h00, res}, 8'h01);
        u_host.prog(1'b0, 13'h0400, 8'h5A, res);
        mem(13'h0400, 8'h00);
        u_host.prog(1'b1, 13'h0401, 8'h0F, res);
        mem(13'h0401, 8'h0F);
        u_host.prog(1'b0, 13'h0600, 8'h00, res);
        check({6'h00, res}, 8'h02);
        u_host.prog(1'b1, 13'h0000, 8'h00, res);
        check({6'h00, res}, 8'h02);
        u_host.wr(CS, 8'h11);
        u_host.prog(1'b1, 13'h0402, 8'h00, res);
        check({6'h00, res}, 8'h02);
        u_host.wr(PP, 8'h00);
        unl(8'h00);
        u_host.wr(CS, FPC_CMD_PAGE_ERASE);
        check({7'h00, stall}, 8'h00);
        st(8'hFF, 8'h00);
        $display("page program done");
        resetn = 1'b0;
        @(posedge clk) #1 resetn = 1'b1;
        u_host.wr(CS, FPC_CMD_PROT_SEL);
        u_host.rd(PP, v);
        check(v, 8'h00);
        u_host.wr(CS, FPC_CMD_RESET);
        unl(8'h00);
        erase(FPC_CMD_MASS_ERASE, 8'h20);
        mem(13'h0401, 8'hFF);
        u_host.prog(1'b1, 13'h1FFF, 8'h3C, res);
        mem(13'h1FFF, 8'h3C);
        $display("mass erase done");
        summarize();
    end
endmodule
